// ==== rtl/msas_top.sv ====
// How it works
// - Scanned registers take serial bits at the MSB; LSB feeds downstream.
// - Address match looks at the six low bits only; top two ignored.
// - Codes 00-3A are direct addresses; 3B broadcasts to every bridge.
// - Codes 3C-3F select group 0-3 when the group register agrees.
// - Broadcast or group selection keeps the data output undriven.
// - Test-Logic-Reset returns selection to awaiting an address.
// - The return-to-wait instruction returns selected or unselected bridges.
// - While awaiting, compare instruction bits 5..0 with slot at Update-IR.
// - On match become selected with the identification register in path.
// - A non-matching bridge stays unselected until reset or return-to-wait.
// - A selected bridge presents a single chain upstream.
// - Before selection, instruction shifting never drives the data output.
// - Group register is reachable only after single direct selection.
module msas_top
  import msas_pkg::*;
(
  input  wire logic                           clk_sys,
  input  wire logic                           arst_n,
  input  wire logic                           tck_b,
  input  wire logic                           tms_b,
  input  wire logic                           backplane_data_in,
  input  wire logic [msas_pkg::ADDR_W-1:0]    slot_addr,
  output logic                                backplane_data_out,
  output logic                                backplane_data_out_oe,
  output logic                                bridge_selected,
  output logic                                evt_valid,
  output logic [msas_pkg::EVT_W-1:0]          evt_data,
  input  wire logic                           evt_ready
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] slot_s1_reg;
  logic [ADDR_W-1:0] slot_s2_reg;
  msas_tap_e         tap_reg;
  msas_tap_e         tap_next;
  msas_sel_e         sel_reg;
  msas_sel_e         sel_next;
  logic [IR_W-1:0]   ir_sh_reg;
  logic [IR_W-1:0]   ir_sh_next;
  logic [IR_W-1:0]   instr_reg;
  logic [IR_W-1:0]   instr_next;
  logic [DR_W-1:0]   dr_sh_reg;
  logic [DR_W-1:0]   dr_sh_next;
  logic [GRP_W-1:0]  grp_reg;
  logic [GRP_W-1:0]  grp_next;
  logic              req_reg;
  logic              req_next;
  logic [EVT_W-1:0]  hold_reg;
  logic [EVT_W-1:0]  hold_next;
  logic              ack_s1_reg;
  logic              ack_s2_reg;
  logic              sel_tck_reg;
  logic              sel_tck_next;
  logic              tdo_reg;
  logic              tdo_next;
  logic              oe_reg;
  logic              oe_next;
  msas_dr_e          dr_act;
  logic              req_s1_reg;
  logic              req_s2_reg;
  logic              seen_reg;
  logic              seen_next;
  logic              sel_s1_reg;
  logic              sel_s2_reg;
  logic              evt_valid_reg;
  logic              evt_valid_next;
  logic [EVT_W-1:0]  evt_data_reg;
  logic [EVT_W-1:0]  evt_data_next;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [EVT_W-1:0]  fifo_out_data;
  logic              push;

  // Data register in the path for a given selection and instruction
  function automatic msas_dr_e dr_pick(msas_sel_e s, logic [IR_W-1:0] op);
    if (s == SEL_WAIT || s == SEL_UNSEL)
      dr_pick = DR_BYP;
    else if (op == OP_BYPASS)
      dr_pick = DR_BYP;
    else if (op == OP_GROUP_SEL && s == SEL_SINGLE)
      dr_pick = DR_GRP;
    else
      dr_pick = DR_ID;
  endfunction : dr_pick

  // Level-1 address decode; group codes outrank a direct slot match
  function automatic msas_sel_e addr_decode(logic [IR_W-1:0] ir,
                                            logic [ADDR_W-1:0] slot,
                                            logic [GRP_W-1:0] grp);
    if (ir[ADDR_W-1:0] == ADDR_BROADCAST)
      addr_decode = SEL_GROUP;
    else if (ir[ADDR_W-1:GRP_W] == ADDR_GROUP_PFX)
      addr_decode = (ir[GRP_W-1:0] == grp) ? SEL_GROUP : SEL_UNSEL;
    else if (ir[ADDR_W-1:0] == slot)
      addr_decode = SEL_SINGLE;
    else
      addr_decode = SEL_UNSEL;
  endfunction : addr_decode

  assign dr_act = dr_pick(sel_reg, instr_reg);

  // ---------------------------------------------------------------
  // Link side: tap, selection and scan registers
  // ---------------------------------------------------------------
  always_comb
  begin
    tap_next   = msas_tap_step(tap_reg, tms_b);
    sel_next   = sel_reg;
    ir_sh_next = ir_sh_reg;
    instr_next = instr_reg;
    dr_sh_next = dr_sh_reg;
    grp_next   = grp_reg;
    req_next   = req_reg;
    hold_next  = hold_reg;
    case (tap_reg)
      TAP_CAP_IR: ir_sh_next = IR_CAPTURE_VAL;
      TAP_SH_IR:  ir_sh_next = {backplane_data_in, ir_sh_reg[IR_W-1:1]};
      TAP_CAP_DR:
      begin
        case (dr_act)
          DR_ID:   dr_sh_next = IDCODE_VAL;
          DR_GRP:  dr_sh_next = {{(DR_W-GRP_W){1'h0}}, grp_reg};
          default: dr_sh_next = '0;
        endcase
      end
      TAP_SH_DR:
      begin
        case (dr_act)
          DR_BYP:  dr_sh_next[0] = backplane_data_in;
          DR_GRP:  dr_sh_next[GRP_W-1:0] = {backplane_data_in,
                                            dr_sh_reg[GRP_W-1]};
          default: dr_sh_next = {backplane_data_in,
                                 dr_sh_reg[DR_W-1:1]};
        endcase
      end
      TAP_UPD_DR:
      begin
        if (dr_act == DR_GRP)
          grp_next = dr_sh_reg[GRP_W-1:0];
      end
      TAP_UPD_IR:
      begin
        case (sel_reg)
          SEL_WAIT:
          begin
            sel_next = addr_decode(ir_sh_reg, slot_s2_reg, grp_reg);
            instr_next = OP_IDCODE;
          end
          default:
          begin
            if (ir_sh_reg == OP_RETURN_WAIT)
              sel_next = SEL_WAIT;
            else if (sel_reg != SEL_UNSEL)
              instr_next = ir_sh_reg;
          end
        endcase
        // Report the update; a report is dropped while one is pending
        if (req_reg == ack_s2_reg)
        begin
          req_next  = ~req_reg;
          hold_next = {sel_next, ir_sh_reg};
        end
      end
      default: ;
    endcase
    if (tap_reg == TAP_TLR)
    begin
      sel_next   = SEL_WAIT;
      instr_next = OP_IDCODE;
    end
    sel_tck_next = (sel_next == SEL_SINGLE) || (sel_next == SEL_GROUP);
  end

  always_ff @(posedge tck_b or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slot_s1_reg <= '0;
      slot_s2_reg <= '0;
      tap_reg     <= TAP_TLR;
      sel_reg     <= SEL_WAIT;
      ir_sh_reg   <= IR_CAPTURE_VAL;
      instr_reg   <= OP_IDCODE;
      dr_sh_reg   <= '0;
      grp_reg     <= GRP_RESET;
      req_reg     <= 1'h0;
      hold_reg    <= '0;
      ack_s1_reg  <= 1'h0;
      ack_s2_reg  <= 1'h0;
      sel_tck_reg <= 1'h0;
    end
    else
    begin
      slot_s1_reg <= slot_addr;
      slot_s2_reg <= slot_s1_reg;
      tap_reg     <= tap_next;
      sel_reg     <= sel_next;
      ir_sh_reg   <= ir_sh_next;
      instr_reg   <= instr_next;
      dr_sh_reg   <= dr_sh_next;
      grp_reg     <= grp_next;
      req_reg     <= req_next;
      hold_reg    <= hold_next;
      ack_s1_reg  <= seen_reg;
      ack_s2_reg  <= ack_s1_reg;
      sel_tck_reg <= sel_tck_next;
    end
  end

  // ---------------------------------------------------------------
  // Link side: data output on the falling edge
  // ---------------------------------------------------------------
  always_comb
  begin
    // One chain upstream: instruction or the chosen data register
    tdo_next = (tap_reg == TAP_SH_IR) ? ir_sh_reg[0] : dr_sh_reg[0];
    // Driven only when directly selected and shifting
    oe_next  = (sel_reg == SEL_SINGLE) &&
               ((tap_reg == TAP_SH_IR) || (tap_reg == TAP_SH_DR));
  end

  always_ff @(negedge tck_b or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tdo_reg <= 1'h0;
      oe_reg  <= 1'h0;
    end
    else
    begin
      tdo_reg <= tdo_next;
      oe_reg  <= oe_next;
    end
  end

  assign backplane_data_out    = tdo_reg;
  assign backplane_data_out_oe = oe_reg;

  // ---------------------------------------------------------------
  // System side: handshake receive, buffer and output stage
  // ---------------------------------------------------------------
  assign push           = (req_s2_reg != seen_reg);
  assign fifo_out_ready = !evt_valid_reg || evt_ready;

  always_comb
  begin
    seen_next      = (push && fifo_in_ready) ? req_s2_reg : seen_reg;
    evt_valid_next = evt_valid_reg && !evt_ready;
    evt_data_next  = evt_data_reg;
    if (fifo_out_valid && fifo_out_ready)
    begin
      evt_valid_next = 1'h1;
      evt_data_next  = fifo_out_data;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_s1_reg    <= 1'h0;
      req_s2_reg    <= 1'h0;
      seen_reg      <= 1'h0;
      sel_s1_reg    <= 1'h0;
      sel_s2_reg    <= 1'h0;
      evt_valid_reg <= 1'h0;
      evt_data_reg  <= '0;
    end
    else
    begin
      req_s1_reg    <= req_reg;
      req_s2_reg    <= req_s1_reg;
      seen_reg      <= seen_next;
      sel_s1_reg    <= sel_tck_reg;
      sel_s2_reg    <= sel_s1_reg;
      evt_valid_reg <= evt_valid_next;
      evt_data_reg  <= evt_data_next;
    end
  end

  msas_fifo #(
    .W (EVT_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (hold_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign bridge_selected = sel_s2_reg;
  assign evt_valid       = evt_valid_reg;
  assign evt_data        = evt_data_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_ir_msb;
    @(posedge tck_b) disable iff (!arst_n)
    (tap_reg == TAP_SH_IR) |=> (ir_sh_reg[IR_W-1] == $past(backplane_data_in));
  endproperty
  a_ir_msb: assert property (p_ir_msb)
    else $error("Instruction bit did not enter at the MSB");

  property p_upper_ignored;
    @(posedge tck_b) disable iff (!arst_n)
    (tap_reg == TAP_UPD_IR && sel_reg == SEL_WAIT &&
     ir_sh_reg[ADDR_W-1:0] == slot_s2_reg &&
     ir_sh_reg[ADDR_W-1:2] != ADDR_GROUP_PFX &&
     ir_sh_reg[ADDR_W-1:0] != ADDR_BROADCAST)
    |=> (sel_reg == SEL_SINGLE && instr_reg == OP_IDCODE);
  endproperty
  a_upper_ignored: assert property (p_upper_ignored)
    else $error("Direct match did not select with identification path");

  property p_broadcast;
    @(posedge tck_b) disable iff (!arst_n)
    (tap_reg == TAP_UPD_IR && sel_reg == SEL_WAIT &&
     ir_sh_reg[ADDR_W-1:0] == ADDR_BROADCAST) |=> (sel_reg == SEL_GROUP);
  endproperty
  a_broadcast: assert property (p_broadcast)
    else $error("Broadcast code did not select the bridge");

  property p_group;
    @(posedge tck_b) disable iff (!arst_n)
    (tap_reg == TAP_UPD_IR && sel_reg == SEL_WAIT &&
     ir_sh_reg[ADDR_W-1:2] == ADDR_GROUP_PFX)
    |=> (sel_reg == (($past(ir_sh_reg[1:0]) == $past(grp_reg)) ?
                     SEL_GROUP : SEL_UNSEL));
  endproperty
  a_group: assert property (p_group)
    else $error("Group code selection wrong");

  property p_group_quiet;
    @(posedge tck_b) disable iff (!arst_n)
    (sel_reg == SEL_GROUP && $past(sel_reg) == SEL_GROUP) |-> !oe_reg;
  endproperty
  a_group_quiet: assert property (p_group_quiet)
    else $error("Data output driven while group selected");

  property p_reset_wait;
    @(posedge tck_b) disable iff (!arst_n)
    (tap_reg == TAP_TLR) |=> (sel_reg == SEL_WAIT);
  endproperty
  a_reset_wait: assert property (p_reset_wait)
    else $error("Test-Logic-Reset did not return to waiting");

  property p_return_wait;
    @(posedge tck_b) disable iff (!arst_n)
    (tap_reg == TAP_UPD_IR && sel_reg != SEL_WAIT &&
     ir_sh_reg == OP_RETURN_WAIT) |=> (sel_reg == SEL_WAIT);
  endproperty
  a_return_wait: assert property (p_return_wait)
    else $error("Return-to-wait instruction ignored");

  property p_stay_unsel;
    @(posedge tck_b) disable iff (!arst_n)
    (sel_reg == SEL_UNSEL && tap_reg != TAP_TLR &&
     !(tap_reg == TAP_UPD_IR && ir_sh_reg == OP_RETURN_WAIT))
    |=> (sel_reg == SEL_UNSEL);
  endproperty
  a_stay_unsel: assert property (p_stay_unsel)
    else $error("Unselected bridge left unselected state");

  property p_quiet_unselected;
    @(posedge tck_b) disable iff (!arst_n)
    (sel_reg inside {SEL_WAIT, SEL_UNSEL} &&
     $past(sel_reg) inside {SEL_WAIT, SEL_UNSEL}) |-> !oe_reg;
  endproperty
  a_quiet_unselected: assert property (p_quiet_unselected)
    else $error("Data output driven before selection");

  property p_group_reg_locked;
    @(posedge tck_b) disable iff (!arst_n)
    (tap_reg == TAP_UPD_DR && sel_reg != SEL_SINGLE) |=> $stable(grp_reg);
  endproperty
  a_group_reg_locked: assert property (p_group_reg_locked)
    else $error("Group register written without direct selection");

  property p_oe_single;
    @(posedge tck_b) disable iff (!arst_n)
    oe_reg |-> ($past(sel_reg) == SEL_SINGLE);
  endproperty
  a_oe_single: assert property (p_oe_single)
    else $error("Data output enabled without single selection");

endmodule : msas_top

// ==== rtl/msas_pkg.sv ====
package msas_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int IR_W       = 8;
  localparam int ADDR_W     = 6;
  localparam int DR_W       = 32;
  localparam int GRP_W      = 2;
  localparam int EVT_W      = 10;
  localparam int FIFO_DEPTH = 8;

  // ---------------------------------------------------------------
  // Address codes and instruction op-codes
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_BROADCAST = 6'h3B;
  localparam logic [3:0]        ADDR_GROUP_PFX = 4'hF;
  localparam logic [IR_W-1:0]   OP_RETURN_WAIT = 8'hC3;
  localparam logic [IR_W-1:0]   OP_BYPASS      = 8'hFF;
  localparam logic [IR_W-1:0]   OP_GROUP_SEL   = 8'h03;
  localparam logic [IR_W-1:0]   OP_IDCODE      = 8'hAA;
  localparam logic [IR_W-1:0]   IR_CAPTURE_VAL = 8'h01;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [GRP_W-1:0]  GRP_RESET      = 2'h0;
  // Arbitrary identification value, bit 0 set as the scan standard wants
  localparam logic [DR_W-1:0]   IDCODE_VAL     = 32'h1357_9BDF;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } msas_tap_e;

  typedef enum logic [1:0] {
    SEL_WAIT, SEL_SINGLE, SEL_GROUP, SEL_UNSEL
  } msas_sel_e;

  typedef enum logic [1:0] {
    DR_ID, DR_BYP, DR_GRP
  } msas_dr_e;

  // ---------------------------------------------------------------
  // Test access port state step
  // ---------------------------------------------------------------
  function automatic msas_tap_e msas_tap_step(msas_tap_e s, logic tms);
    case (s)
      TAP_TLR:    msas_tap_step = tms ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    msas_tap_step = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: msas_tap_step = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: msas_tap_step = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  msas_tap_step = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: msas_tap_step = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: msas_tap_step = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: msas_tap_step = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: msas_tap_step = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: msas_tap_step = tms ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: msas_tap_step = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  msas_tap_step = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: msas_tap_step = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: msas_tap_step = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: msas_tap_step = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: msas_tap_step = tms ? TAP_SEL_DR : TAP_RTI;
      default:    msas_tap_step = TAP_TLR;
    endcase
  endfunction : msas_tap_step

endpackage : msas_pkg

// ==== rtl/msas_fifo.sv ====
module msas_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(D);

  logic [W-1:0]  mem_reg  [D];
  logic [W-1:0]  mem_next [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] wr_next;
  logic [AW-1:0] rd_reg;
  logic [AW-1:0] rd_next;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_reg != FULL);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    mem_next = mem_reg;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push)
    begin
      mem_next[wr_reg] = in_data;
      wr_next = (wr_reg == LAST) ? '0 : wr_reg + AW'(1);
    end
    if (pop)
    begin
      rd_next = (rd_reg == LAST) ? '0 : rd_reg + AW'(1);
    end
    if (push && !pop)
    begin
      cnt_next = cnt_reg + (AW + 1)'(1);
    end
    else if (pop && !push)
    begin
      cnt_next = cnt_reg - (AW + 1)'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mem_reg <= '{default: '0};
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule : msas_fifo

// ==== tb/msas_jtag_ctl.sv ====
module msas_jtag_ctl (
  output logic      tck_b,
  output logic      tms_b,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Backplane test controller
  // ---------------------------------------------------------------
  logic oe_seen;
  logic last_q;
  logic lvl;
  // Released line shows the inverse of its last value
  assign lvl = tdo_oe ? tdo : ~last_q;
  initial
  begin
    tck_b = 1'b0;
    tms_b = 1'b1;
    tdi = 1'b0;
    oe_seen = 1'b0;
    last_q = 1'b0;
  end
  // One test clock; the clock stands still between calls
  task automatic clk1(input logic m, input logic d, output logic q);
    tms_b = m;
    tdi = d;
    #15;
    q = lvl;
    last_q = lvl;
    oe_seen = oe_seen | tdo_oe;
    tck_b = 1'b1;
    #15;
    tck_b = 1'b0;
  endtask : clk1
  task automatic tlr();
    logic q;
    repeat (5) clk1(1'b1, 1'b0, q);
    clk1(1'b0, 1'b0, q);
  endtask : tlr
  // Register scan from idle back to idle, bit 0 first
  task automatic scan(input logic ir, input int n,
                      input logic [31:0] din, output logic [31:0] dout);
    logic q;
    int   i;
    dout = '0;
    clk1(1'b1, 1'b0, q);
    if (ir)
      clk1(1'b1, 1'b0, q);
    clk1(1'b0, 1'b0, q);
    clk1(1'b0, 1'b0, q);
    for (i = 0; i < n; i++)
    begin
      clk1(i == n - 1, din[i], q);
      dout[i] = q;
    end
    clk1(1'b1, 1'b0, q);
    clk1(1'b0, 1'b0, q);
  endtask : scan
endmodule : msas_jtag_ctl

// ==== tb/msas_top_tb_top.sv ====
module msas_top_tb_top;
  import msas_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic              evt_ready = 1'b1;
  logic [ADDR_W-1:0] slot = 6'h15;
  logic              tck, tms, tdi, tdo, oe, sel, evv;
  logic [EVT_W-1:0]  evd;
  logic [EVT_W-1:0]  evq[$];
  logic [31:0]       r;
  int                n_fail = 0;
  int                num_checks = 0;
  int                g;

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (evv === 1'b1 && evt_ready === 1'b1)
      evq.push_back(evd);

  msas_top u_msas_top (.clk_sys(clk_sys), .arst_n(arst_n), .tck_b(tck),
    .tms_b(tms), .backplane_data_in(tdi), .slot_addr(slot),
    .backplane_data_out(tdo), .backplane_data_out_oe(oe),
    .bridge_selected(sel), .evt_valid(evv), .evt_data(evd),
    .evt_ready(evt_ready));
  msas_jtag_ctl u_msas_jtag_ctl (.tck_b(tck), .tms_b(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(oe));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Waits for the next report word, then checks it and the selection
  task automatic ld(input logic [7:0] v, input logic [1:0] res,
                    input logic s);
    logic [EVT_W-1:0] w;
    int               k;
    u_msas_jtag_ctl.scan(1'b1, 8, 32'(v), r);
    for (k = 0; k < 400 && evq.size() == 0; k++)
      @(posedge clk_sys);
    w = (evq.size() != 0) ? evq.pop_front() : '1;
    repeat (4) @(posedge clk_sys);
    chk(32'(w), 32'({res, v}));
    chk(32'(sel), 32'(s));
  endtask : ld
  task automatic t_direct();
    u_msas_jtag_ctl.tlr();
    u_msas_jtag_ctl.oe_seen = 1'b0;
    ld({2'b11, slot}, 2'd1, 1'b1);
    chk(32'(u_msas_jtag_ctl.oe_seen), 32'h0);
    u_msas_jtag_ctl.scan(1'b0, 32, 32'h0, r);
    chk(r, IDCODE_VAL);
    ld(OP_BYPASS, 2'd1, 1'b1);
    chk(32'(r[7:0]), 32'(IR_CAPTURE_VAL));
    u_msas_jtag_ctl.scan(1'b0, 2, 32'h1, r);
    chk(32'(r[1:0]), 32'h2);
  endtask : t_direct
  task automatic t_unsel();
    u_msas_jtag_ctl.tlr();
    ld(8'h3A, 2'd3, 1'b0);
    ld({2'b01, slot}, 2'd3, 1'b0);
    ld(OP_RETURN_WAIT, 2'd0, 1'b0);
    ld({2'b10, slot}, 2'd1, 1'b1);
    ld(OP_RETURN_WAIT, 2'd0, 1'b0);
  endtask : t_unsel
  task automatic t_group();
    u_msas_jtag_ctl.tlr();
    ld({2'b00, slot}, 2'd1, 1'b1);
    ld(OP_GROUP_SEL, 2'd1, 1'b1);
    u_msas_jtag_ctl.scan(1'b0, 2, 32'h2, r);
    chk(32'(r[1:0]), 32'(GRP_RESET));
    for (g = 0; g < 4; g++)
    begin
      u_msas_jtag_ctl.tlr();
      ld({2'b01, ADDR_GROUP_PFX, 2'(g)}, (g == 2) ? 2'd2 : 2'd3,
         g == 2);
    end
    // Group-selected again, so the quiet output is judged in group mode
    u_msas_jtag_ctl.tlr();
    ld({2'b11, ADDR_GROUP_PFX, 2'd2}, 2'd2, 1'b1);
    u_msas_jtag_ctl.oe_seen = 1'b0;
    u_msas_jtag_ctl.scan(1'b0, 32, 32'h0, r);
    chk(32'(u_msas_jtag_ctl.oe_seen), 32'h0);
  endtask : t_group
  task automatic t_bcast();
    u_msas_jtag_ctl.tlr();
    ld({2'b10, ADDR_BROADCAST}, 2'd2, 1'b1);
    u_msas_jtag_ctl.oe_seen = 1'b0;
    u_msas_jtag_ctl.scan(1'b0, 32, 32'h0, r);
    chk(32'(u_msas_jtag_ctl.oe_seen), 32'h0);
    u_msas_jtag_ctl.tlr();
    repeat (8) @(posedge clk_sys);
    chk(32'(sel), 32'h0);
  endtask : t_bcast
  // Overfills the report path while the consumer stalls; one report drops
  task automatic t_fifo();
    int k;
    @(posedge clk_sys);
    #1 evt_ready = 1'b0;
    for (k = 0; k < 11; k++)
      u_msas_jtag_ctl.scan(1'b1, 8, 32'h3A, r);
    chk(32'(evv), 32'h1);
    @(posedge clk_sys);
    #1 evt_ready = 1'b1;
    repeat (60) @(posedge clk_sys);
    chk(32'(evq.size()), 32'd10);
    chk(32'(evq[0]), 32'({2'd3, 8'h3A}));
    evq.delete();
  endtask : t_fifo

  initial
  begin
    repeat (16) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    t_direct();
    t_unsel();
    t_group();
    t_bcast();
    t_fifo();
    tally_and_finish();
  end
  initial
  begin
    #1000000;
    n_fail++;
    tally_and_finish();
  end
endmodule : msas_top_tb_top
